// ===== rtl/acr_pkg.sv
// Package of constants for the acquisition control and status register block
package acr_pkg;
    // ========================================================
    // Register offsets on the 4-bit host I/O address
    localparam logic [3:0] OFF_STATUS_PRIMARY = 4'h0;
    localparam logic [3:0] OFF_CHANNEL_CTRL = 4'h0;
    localparam logic [3:0] OFF_ERROR_DETAIL = 4'h1;
    localparam logic [3:0] OFF_ACQ_CLEAR = 4'h1;
    localparam logic [3:0] OFF_RANGE_SELECT = 4'h5;
    localparam logic [3:0] OFF_TIMER_IRQ_CLEAR = 4'h6;
    localparam logic [3:0] OFF_CAL_SCAN_CTRL = 4'h7;

    // ========================================================
    // Field positions, channel and interrupt control
    localparam int CH_SCAN_EN_N_BIT = 7;
    localparam int CH_TIMER_IRQ_EN_BIT = 6;
    localparam int CH_EXT_IRQ_EN_BIT = 5;
    localparam int CH_RESULT_IRQ_EN_BIT = 4;
    // Calibration and scan control
    localparam int CS_SCAN_DIR_BIT = 2;
    localparam int CS_ACQ_DISABLE_BIT = 1;
    localparam int CS_CAL_ENABLE_BIT = 0;
    // Primary status
    localparam int ST_REVISION_BIT = 7;
    localparam int ST_BUSY_BIT = 4;
    localparam int ST_EXT_IRQ_BIT = 3;
    localparam int ST_TIMER_IRQ_BIT = 2;
    localparam int ST_DATA_ERROR_BIT = 1;
    localparam int ST_WAITING_BIT = 0;
    // Error detail
    localparam int ED_OVERFLOW_BIT = 1;
    localparam int ED_OVERRUN_BIT = 0;

    // ========================================================
    // Values after reset
    localparam logic [3:0] RST_CHANNEL = 4'h0;
    localparam logic RST_SCAN_EN_N = 1'b1;
    localparam logic [1:0] RST_RANGE = 2'h2;
    localparam logic RST_ZERO = 1'b0;

    // ========================================================
    // Timing: calibration run length at 125 MHz
    localparam int CLK_FREQ_HZ = 125000000;
    localparam int CAL_TIME_MS = 10;
    localparam int CAL_CYCLES = (CLK_FREQ_HZ / 1000) * CAL_TIME_MS;
    localparam int CAL_CNT_W = 24;

    // Scan sequencer states
    typedef enum logic [1:0] {
        ACR_SCAN_IDLE,
        ACR_SCAN_RUN
    } acr_scan_state_t;
endpackage : acr_pkg

// ===== rtl/acr_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module acr_sync
    import acr_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic rst_value,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;
    logic stage2;
    logic stage3;

    // ========================================================
    // Stage one feeds stage two only
    always_ff @(posedge mclk) begin
        if (reset) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Change counts once second and third stages agree
    always_ff @(posedge mclk) begin
        if (reset) begin
            sync_out <= 1'b0;
        end else if (stage2 == stage3) begin
            sync_out <= stage3;
        end
    end
    // rst_value chosen by the parent through an inverter around the cell
    logic unused_rst;
    assign unused_rst = rst_value;
endmodule : acr_sync

// ===== rtl/acr_cal_timer.sv
// Auto-calibration run timer
`timescale 1ns/1ps
module acr_cal_timer
    import acr_pkg::*;
#(
    parameter int CAL_LEN = CAL_CYCLES
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic start,
    output logic busy
);
    logic [CAL_CNT_W-1:0] remaining;

    // ========================================================
    // Counts the run down; a new start during a run restarts it
    always_ff @(posedge mclk) begin
        if (reset) begin
            remaining <= '0;
        end else if (start) begin
            remaining <= CAL_CNT_W'(CAL_LEN);
        end else if (remaining != '0) begin
            remaining <= remaining - CAL_CNT_W'(1);
        end
    end

    assign busy = (remaining != '0);
endmodule : acr_cal_timer

// ===== rtl/acr_regs.sv
// Control and status registers of the multiplexed A/D acquisition unit
//
// Behaviour
// - Result interrupt enable resets clear; when set, waiting results raise interrupt.
// - Four-bit channel field, reset 0000, picks one of sixteen mux inputs.
// - Scan enable low samples channels from channel field down to zero.
// - Scan direction picks upward from zero or downward from field.
// - Scan enable high samples only the channel field's channel.
// - Acquisition disable resets clear; set blocks both conversion triggers.
// - Calibration starts on write of enable one then read of register.
// - A calibration run lasts about ten milliseconds.
// - Busy flag stays set during calibration for software polling.
// - Two-bit range field selects input range, resets to binary 10.
// - Status bit 7 revision flag always reads one.
// - Status bit 3 mirrors the active-low external interrupt input.
// - With timer interrupt enabled, counter 2 rising edge sets timer flag; timer-clear-register write clears it.
// - Status bit 1 sets on FIFO overflow, cleared by clear-register write.
// - Status bit 0 exactly tracks a non-empty result FIFO.
// - Error detail bit 1 sets on overflow, cleared by clear-register write.
// - External interrupt enable resets clear; when set, low input interrupts.
`timescale 1ns/1ps
module acr_regs
    import acr_pkg::*;
#(
    parameter int CAL_LEN = CAL_CYCLES
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [3:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    output logic [7:0] io_rdata,
    input wire logic fifo_not_empty,
    input wire logic fifo_overflow,
    input wire logic conv_overrun,
    input wire logic conv_active,
    input wire logic conv_done,
    input wire logic counter0_trigger_n,
    input wire logic external_convert_n,
    input wire logic counter2_out,
    input wire logic external_irq_n,
    output logic convert_start,
    output logic [3:0] mux_channel,
    output logic [1:0] input_range_field,
    output logic calibration_start,
    output logic calibration_enable,
    output logic fifo_clear,
    output logic irq
);
    // ========================================================
    // Register state
    logic [3:0] channel_field;
    logic scan_enable_n;
    logic timer_irq_enable;
    logic external_irq_enable;
    logic result_irq_enable;
    logic scan_direction;
    logic acquisition_disable;
    logic cal_armed;
    logic timer_irq_flag;
    logic data_error_flag;
    logic overrun_flag;
    logic cal_busy;
    logic [3:0] scan_channel;
    logic [3:0] next_scan_channel;
    acr_scan_state_t scan_state;
    logic ext_irq_sync;
    logic cnt2_sync;
    logic cnt2_prev;
    logic ctr0_sync;
    logic external_convert_n_sync;
    logic ctr0_prev;
    logic external_convert_n_prev;
    logic result_waiting_flag;
    logic conversion_busy_flag;

    // Access decode
    function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
        hit = (addr == off);
    endfunction : hit

    logic wr_chan;
    logic wr_cal;
    logic wr_range;
    logic wr_clear;
    logic wr_tclear;
    logic rd_cal;
    assign wr_chan = io_wr && hit(io_addr, OFF_CHANNEL_CTRL);
    assign wr_cal = io_wr && hit(io_addr, OFF_CAL_SCAN_CTRL);
    assign wr_range = io_wr && hit(io_addr, OFF_RANGE_SELECT);
    assign wr_clear = io_wr && hit(io_addr, OFF_ACQ_CLEAR);
    assign wr_tclear = io_wr && hit(io_addr, OFF_TIMER_IRQ_CLEAR);
    assign rd_cal = io_rd && hit(io_addr, OFF_CAL_SCAN_CTRL);

    // ========================================================
    // Pin inputs pass the three-stage synchroniser
    acr_sync u_sync_ext (
        .mclk(mclk), .reset(reset), .rst_value(1'b1),
        .async_in(~external_irq_n), .sync_out(ext_irq_sync)
    );
    acr_sync u_sync_cnt2 (
        .mclk(mclk), .reset(reset), .rst_value(1'b0),
        .async_in(counter2_out), .sync_out(cnt2_sync)
    );
    acr_sync u_sync_ctr0 (
        .mclk(mclk), .reset(reset), .rst_value(1'b0),
        .async_in(~counter0_trigger_n), .sync_out(ctr0_sync)
    );
    acr_sync u_sync_external_convert_n (
        .mclk(mclk), .reset(reset), .rst_value(1'b0),
        .async_in(~external_convert_n), .sync_out(external_convert_n_sync)
    );

    // ========================================================
    // Channel and interrupt control register
    always_ff @(posedge mclk) begin
        if (reset) begin
            channel_field <= RST_CHANNEL;
            scan_enable_n <= RST_SCAN_EN_N;
            timer_irq_enable <= RST_ZERO;
            external_irq_enable <= RST_ZERO;
            result_irq_enable <= RST_ZERO;
        end else if (wr_chan) begin
            channel_field <= io_wdata[3:0];
            scan_enable_n <= io_wdata[CH_SCAN_EN_N_BIT];
            timer_irq_enable <= io_wdata[CH_TIMER_IRQ_EN_BIT];
            external_irq_enable <= io_wdata[CH_EXT_IRQ_EN_BIT];
            result_irq_enable <= io_wdata[CH_RESULT_IRQ_EN_BIT];
        end
    end

    // Calibration and scan control; reserved bits are dropped
    always_ff @(posedge mclk) begin
        if (reset) begin
            scan_direction <= RST_ZERO;
            acquisition_disable <= RST_ZERO;
            calibration_enable <= RST_ZERO;
        end else if (wr_cal) begin
            scan_direction <= io_wdata[CS_SCAN_DIR_BIT];
            acquisition_disable <= io_wdata[CS_ACQ_DISABLE_BIT];
            calibration_enable <= io_wdata[CS_CAL_ENABLE_BIT];
        end
    end

    // Range select; only the low two bits are kept
    always_ff @(posedge mclk) begin
        if (reset) begin
            input_range_field <= RST_RANGE;
        end else if (wr_range) begin
            input_range_field <= io_wdata[1:0];
        end
    end

    // ========================================================
    // Calibration start: the write arms, the following read fires
    always_ff @(posedge mclk) begin
        if (reset) begin
            cal_armed <= 1'b0;
        end else if (wr_cal) begin
            cal_armed <= io_wdata[CS_CAL_ENABLE_BIT];
        end else if (rd_cal) begin
            cal_armed <= 1'b0;
        end
    end
    assign calibration_start = rd_cal && cal_armed && calibration_enable;

    acr_cal_timer #(
        .CAL_LEN(CAL_LEN)
    ) u_cal_timer (
        .mclk(mclk),
        .reset(reset),
        .start(calibration_start),
        .busy(cal_busy)
    );

    // ========================================================
    // Conversion triggers; falling edges of active-low inputs, gated
    always_ff @(posedge mclk) begin
        if (reset) begin
            ctr0_prev <= 1'b0;
            external_convert_n_prev <= 1'b0;
        end else begin
            ctr0_prev <= ctr0_sync;
            external_convert_n_prev <= external_convert_n_sync;
        end
    end
    assign convert_start = !acquisition_disable && !cal_busy &&
        ((ctr0_sync && !ctr0_prev) || (external_convert_n_sync && !external_convert_n_prev));

    // ========================================================
    // Scan sequencer; a write with scan enable high reloads the counter
    always_comb begin
        next_scan_channel = scan_channel;
        if (scan_direction) begin
            if (scan_channel >= channel_field) begin
                next_scan_channel = 4'h0;
            end else begin
                next_scan_channel = scan_channel + 4'h1;
            end
        end else begin
            if (scan_channel == 4'h0) begin
                next_scan_channel = channel_field;
            end else begin
                next_scan_channel = scan_channel - 4'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            scan_state <= ACR_SCAN_IDLE;
            scan_channel <= RST_CHANNEL;
        end else if (wr_chan) begin
            // Upward scans start at zero, downward at the field
            scan_channel <= io_wdata[CH_SCAN_EN_N_BIT] ? (scan_direction ? 4'h0 :
                io_wdata[3:0]) : scan_channel;
            scan_state <= io_wdata[CH_SCAN_EN_N_BIT] ? ACR_SCAN_IDLE : ACR_SCAN_RUN;
        end else begin
            case (scan_state)
                ACR_SCAN_IDLE: begin
                    scan_state <= ACR_SCAN_IDLE;
                end
                ACR_SCAN_RUN: begin
                    if (conv_done) begin
                        scan_channel <= next_scan_channel;
                    end
                end
                default: begin
                    scan_state <= ACR_SCAN_IDLE;
                end
            endcase
        end
    end
    // Single channel when scan enable is high
    assign mux_channel = scan_enable_n ? channel_field : scan_channel;

    // ========================================================
    // Timer interrupt flag; a new edge wins over a clear
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt2_prev <= 1'b0;
            timer_irq_flag <= 1'b0;
        end else begin
            cnt2_prev <= cnt2_sync;
            if (timer_irq_enable && cnt2_sync && !cnt2_prev) begin
                timer_irq_flag <= 1'b1;
            end else if (wr_tclear) begin
                timer_irq_flag <= 1'b0;
            end
        end
    end

    // Error flags; set wins over the clear register write
    always_ff @(posedge mclk) begin
        if (reset) begin
            data_error_flag <= 1'b0;
            overrun_flag <= 1'b0;
        end else begin
            if (fifo_overflow) begin
                data_error_flag <= 1'b1;
            end else if (wr_clear) begin
                data_error_flag <= 1'b0;
            end
            if (conv_overrun) begin
                overrun_flag <= 1'b1;
            end else if (wr_clear) begin
                overrun_flag <= 1'b0;
            end
        end
    end
    // Same latch serves both overflow bits, keeping them identical
    assign fifo_clear = wr_clear;

    // ========================================================
    // Status and interrupt
    assign result_waiting_flag = fifo_not_empty;
    assign conversion_busy_flag = conv_active || cal_busy;
    assign irq = (result_irq_enable && result_waiting_flag) ||
        (timer_irq_enable && timer_irq_flag) ||
        (external_irq_enable && ext_irq_sync);

    // Read data registered; unmapped offsets read zero
    always_ff @(posedge mclk) begin
        if (reset) begin
            io_rdata <= 8'h00;
        end else if (io_rd) begin
            io_rdata <= 8'h00;
            case (io_addr)
                OFF_STATUS_PRIMARY: begin
                    io_rdata[ST_REVISION_BIT] <= 1'b1;
                    io_rdata[ST_BUSY_BIT] <= conversion_busy_flag;
                    io_rdata[ST_EXT_IRQ_BIT] <= !ext_irq_sync;
                    io_rdata[ST_TIMER_IRQ_BIT] <= timer_irq_flag;
                    io_rdata[ST_DATA_ERROR_BIT] <= data_error_flag;
                    io_rdata[ST_WAITING_BIT] <= result_waiting_flag;
                end
                OFF_ERROR_DETAIL: begin
                    io_rdata[ED_OVERFLOW_BIT] <= data_error_flag;
                    io_rdata[ED_OVERRUN_BIT] <= overrun_flag;
                end
                OFF_CAL_SCAN_CTRL: begin
                    io_rdata[CS_SCAN_DIR_BIT] <= scan_direction;
                    io_rdata[CS_ACQ_DISABLE_BIT] <= acquisition_disable;
                    io_rdata[CS_CAL_ENABLE_BIT] <= calibration_enable;
                end
                default: begin
                    io_rdata <= 8'h00;
                end
            endcase
        end
    end
endmodule : acr_regs

// ===== dv/acr_regs_checker.sv
// Concurrent checks on the acquisition register block ports
`timescale 1ns/1ps
module acr_regs_checker
    import acr_pkg::*;
#(
    parameter int CAL_LEN = CAL_CYCLES
)
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic [3:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_rdata,
    input wire logic [3:0] mux_channel,
    input wire logic [1:0] input_range_field,
    input wire logic calibration_start,
    input wire logic calibration_enable,
    input wire logic fifo_clear,
    input wire logic irq,
    input wire logic convert_start
);
    // ========================================================
    // Shared clocking and request shapes
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    sequence chan_load;
        io_wr && io_addr == OFF_CHANNEL_CTRL && io_wdata[CH_SCAN_EN_N_BIT];
    endsequence
    sequence cal_fire;
        calibration_start;
    endsequence
    sequence acq_off;
        io_wr && io_addr == OFF_CAL_SCAN_CTRL && io_wdata[CS_ACQ_DISABLE_BIT];
    endsequence

    // ========================================================
    // Assertions
    chk_cal_start_src: assert property (
        cal_fire |-> io_rd && io_addr == OFF_CAL_SCAN_CTRL && calibration_enable)
        else $error("calibration start without enabled read");
    chk_cal_en_write: assert property (
        io_wr && io_addr == OFF_CAL_SCAN_CTRL |=> calibration_enable == $past(io_wdata[0]))
        else $error("calibration enable not written");
    chk_clear_pulse: assert property (
        fifo_clear == (io_wr && io_addr == OFF_ACQ_CLEAR))
        else $error("fifo clear does not match clear write");
    chk_single_channel: assert property (
        chan_load |=> mux_channel == $past(io_wdata[3:0]))
        else $error("mux channel differs from written field");
    chk_range_write: assert property (
        io_wr && io_addr == OFF_RANGE_SELECT |=> input_range_field == $past(io_wdata[1:0]))
        else $error("range field not written");
    chk_revision_read: assert property (
        io_rd && io_addr == OFF_STATUS_PRIMARY |=> io_rdata[ST_REVISION_BIT])
        else $error("revision flag read low");
    chk_reset_values: assert property (
        $fell(reset) |-> !irq && mux_channel == 4'h0 && input_range_field == 2'h2)
        else $error("wrong value after reset");
    chk_cal_blocks: assert property (
        cal_fire |=> !convert_start [*8])
        else $error("conversion started during calibration");
    chk_disable_blocks: assert property (
        acq_off |=> !convert_start [*8])
        else $error("conversion started while disabled");
    chk_rdata_holds: assert property (
        !io_rd |=> $stable(io_rdata))
        else $error("read data changed without read");
endmodule : acr_regs_checker

bind acr_regs acr_regs_checker #(.CAL_LEN(CAL_LEN)) u_chk (
    .mclk(mclk), .reset(reset), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .mux_channel(mux_channel),
    .input_range_field(input_range_field), .calibration_start(calibration_start),
    .calibration_enable(calibration_enable), .fifo_clear(fifo_clear), .irq(irq),
    .convert_start(convert_start)
);

// ===== dv/acr_host_model.sv
// Host processor model driving 8-bit register I/O cycles
`timescale 1ns/1ps
module acr_host_model
    import acr_pkg::*;
(
    input wire logic mclk,
    input wire logic [7:0] io_rdata,
    output logic [3:0] io_addr,
    output logic [7:0] io_wdata,
    output logic io_wr,
    output logic io_rd
);
    // Idle bus: strobes low, data scrambled so stale values never look valid
    initial begin
        io_addr = 4'hF;
        io_wdata = 8'hA5;
        io_wr = 1'b0;
        io_rd = 1'b0;
    end

    // One write cycle; reserved upper bits go out as zero for the calibration and range registers only
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge mclk);
        io_addr = a;
        io_wdata = (a == OFF_CAL_SCAN_CTRL) ? (d & 8'h07) : d;
        if (a == OFF_RANGE_SELECT) io_wdata = d & 8'h03;
        io_wr = 1'b1;
        @(negedge mclk);
        io_wr = 1'b0;
        io_wdata = ~io_wdata;
    endtask : wr

    // One read cycle; data taken a cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge mclk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge mclk);
        io_rd = 1'b0;
        d = io_rdata;
    endtask : rd
endmodule : acr_host_model

// ===== dv/tb_adc_control_status_regs.sv
// Self-checking testbench of the acquisition control and status registers
`timescale 1ns/1ps
module tb_adc_control_status_regs
    import acr_pkg::*;
;
    localparam int CAL_SIM = 20;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic fifo_not_empty = 1'b0, fifo_overflow = 1'b0, conv_overrun = 1'b0;
    logic conv_active = 1'b0, conv_done = 1'b0, counter2_out = 1'b0;
    logic counter0_trigger_n = 1'b1, external_convert_n = 1'b1, external_irq_n = 1'b1;
    logic [3:0] io_addr, mux_channel;
    logic [7:0] io_wdata, io_rdata;
    logic io_wr, io_rd, convert_start, calibration_start, calibration_enable;
    logic fifo_clear, irq;
    logic [1:0] input_range_field;
    logic [1:0] rng [3] = '{2'h0, 2'h3, 2'h2};
    int fails = 0;
    int tests_run = 0;
    int n_conv = 0;

    acr_regs #(.CAL_LEN(CAL_SIM)) dut (.mclk(mclk), .reset(reset), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata),
        .fifo_not_empty(fifo_not_empty), .fifo_overflow(fifo_overflow),
        .conv_overrun(conv_overrun), .conv_active(conv_active), .conv_done(conv_done),
        .counter0_trigger_n(counter0_trigger_n), .external_convert_n(external_convert_n),
        .counter2_out(counter2_out), .external_irq_n(external_irq_n),
        .convert_start(convert_start), .mux_channel(mux_channel),
        .input_range_field(input_range_field), .calibration_start(calibration_start),
        .calibration_enable(calibration_enable), .fifo_clear(fifo_clear), .irq(irq));
    acr_host_model host (.mclk(mclk), .io_rdata(io_rdata), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd));

    // ========================================================
    // Clock, conversion counter, helpers
    initial forever #4 mclk = ~mclk;
    always @(posedge mclk) if (convert_start === 1'b1) n_conv++;

    task automatic end_of_test();
        if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_byte
    task automatic cmp_sig(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_sig
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        cmp_byte(d, exp);
    endtask : rd_chk
    task automatic pulse(ref logic s);
        @(negedge mclk);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask : pulse
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        end_of_test();
    end

    // ========================================================
    // Test sequence
    initial begin
        tick(12);
        reset = 1'b0;
        cmp_sig(mux_channel, 4'h0);
        cmp_sig({2'b00, input_range_field}, 4'h2);
        tick(5);
        rd_chk(OFF_STATUS_PRIMARY, 8'h88);
        rd_chk(OFF_ERROR_DETAIL, 8'h00);
        rd_chk(4'hF, 8'h00);
        host.wr(4'hC, 8'hFF);
        rd_chk(OFF_CAL_SCAN_CTRL, 8'h00);
        host.wr(OFF_CAL_SCAN_CTRL, 8'hFE);
        rd_chk(OFF_CAL_SCAN_CTRL, 8'h06);
        host.wr(OFF_CAL_SCAN_CTRL, 8'h00);
        // Every channel code, single-channel mode holds across conversions
        for (int c = 0; c < 16; c++) begin
            host.wr(OFF_CHANNEL_CTRL, {4'h8, 4'(c)});
            cmp_sig(mux_channel, 4'(c));
            pulse(conv_done);
            cmp_sig(mux_channel, 4'(c));
        end
        for (int i = 0; i < 3; i++) begin
            host.wr(OFF_RANGE_SELECT, {6'h00, rng[i]});
            cmp_sig({2'b00, input_range_field}, {2'b00, rng[i]});
        end
        // Downward scan from channel 3, then upward scan to channel 2
        host.wr(OFF_CHANNEL_CTRL, 8'h83);
        host.wr(OFF_CHANNEL_CTRL, 8'h03);
        cmp_sig(mux_channel, 4'h3);
        for (int i = 0; i < 4; i++) begin
            pulse(conv_done);
            cmp_sig(mux_channel, 4'(3 - ((i + 1) % 4)));
        end
        host.wr(OFF_CAL_SCAN_CTRL, 8'h04);
        host.wr(OFF_CHANNEL_CTRL, 8'h82);
        host.wr(OFF_CHANNEL_CTRL, 8'h02);
        cmp_sig(mux_channel, 4'h0);
        for (int i = 0; i < 3; i++) begin
            pulse(conv_done);
            cmp_sig(mux_channel, 4'((i + 1) % 3));
        end
        // Calibration: busy for the run, triggers ignored meanwhile
        host.wr(OFF_CAL_SCAN_CTRL, 8'h01);
        rd_chk(OFF_CAL_SCAN_CTRL, 8'h01);
        counter0_trigger_n = 1'b0;
        rd_chk(OFF_STATUS_PRIMARY, 8'h98);
        tick(CAL_SIM - 10);
        rd_chk(OFF_STATUS_PRIMARY, 8'h98);
        tick(8);
        rd_chk(OFF_STATUS_PRIMARY, 8'h88);
        counter0_trigger_n = 1'b1;
        host.wr(OFF_CAL_SCAN_CTRL, 8'h00);
        cmp_sig(4'(n_conv), 4'h0);
        conv_active = 1'b1;
        rd_chk(OFF_STATUS_PRIMARY, 8'h98);
        conv_active = 1'b0;
        // External conversion trigger passes when enabled, blocked when disabled
        external_convert_n = 1'b0;
        tick(8);
        external_convert_n = 1'b1;
        cmp_sig(4'(n_conv), 4'h1);
        host.wr(OFF_CAL_SCAN_CTRL, 8'h02);
        external_convert_n = 1'b0;
        tick(8);
        external_convert_n = 1'b1;
        cmp_sig(4'(n_conv), 4'h1);
        host.wr(OFF_CAL_SCAN_CTRL, 8'h00);
        // Interrupt sources, each under its own enable
        host.wr(OFF_CHANNEL_CTRL, 8'h90);
        fifo_not_empty = 1'b1;
        tick(1);
        cmp_sig({3'b000, irq}, 4'h1);
        rd_chk(OFF_STATUS_PRIMARY, 8'h89);
        fifo_not_empty = 1'b0;
        tick(1);
        cmp_sig({3'b000, irq}, 4'h0);
        host.wr(OFF_CHANNEL_CTRL, 8'hA0);
        external_irq_n = 1'b0;
        tick(6);
        cmp_sig({3'b000, irq}, 4'h1);
        rd_chk(OFF_STATUS_PRIMARY, 8'h80);
        external_irq_n = 1'b1;
        tick(6);
        cmp_sig({3'b000, irq}, 4'h0);
        host.wr(OFF_CHANNEL_CTRL, 8'h80);
        counter2_out = 1'b1;
        tick(6);
        rd_chk(OFF_STATUS_PRIMARY, 8'h88);
        counter2_out = 1'b0;
        host.wr(OFF_CHANNEL_CTRL, 8'hC0);
        tick(6);
        counter2_out = 1'b1;
        tick(6);
        cmp_sig({3'b000, irq}, 4'h1);
        rd_chk(OFF_STATUS_PRIMARY, 8'h8C);
        host.wr(OFF_TIMER_IRQ_CLEAR, 8'h00);
        rd_chk(OFF_STATUS_PRIMARY, 8'h88);
        cmp_sig({3'b000, irq}, 4'h0);
        // Error flags stick until the clear register is written
        pulse(fifo_overflow);
        rd_chk(OFF_STATUS_PRIMARY, 8'h8A);
        rd_chk(OFF_ERROR_DETAIL, 8'h02);
        pulse(conv_overrun);
        rd_chk(OFF_ERROR_DETAIL, 8'h03);
        host.wr(OFF_ACQ_CLEAR, 8'h00);
        rd_chk(OFF_ERROR_DETAIL, 8'h00);
        rd_chk(OFF_STATUS_PRIMARY, 8'h88);
        end_of_test();
    end
endmodule : tb_adc_control_status_regs
